/* rtl/dlm_pkg.sv */
// Package: constants, register map and types for the DLL-mode command block
package dlm_pkg;
  // Register byte addresses
  localparam logic [7:0] REG_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] REG_STATUS_ADDR = 8'h04;
  localparam logic [7:0] REG_MR0_ADDR    = 8'h08;
  localparam logic [7:0] REG_MR1_ADDR    = 8'h0C;
  localparam logic [7:0] REG_MR2_ADDR    = 8'h10;
  // Control field positions and reset value
  localparam int         CTRL_LAUNCH_EN_BIT = 0;
  localparam int         CTRL_ERR_CLR_BIT   = 1;
  localparam logic [1:0] CTRL_RESET         = 2'h1;
  // Status field positions
  localparam int STAT_DLL_EN_BIT  = 0;
  localparam int STAT_LOCKED_BIT  = 1;
  localparam int STAT_SREF_BIT    = 2;
  localparam int STAT_PDN_BIT     = 3;
  localparam int STAT_LAT_ERR_BIT = 4;
  localparam int STAT_CL_LSB      = 8;
  localparam int STAT_CWL_LSB     = 16;
  localparam int STAT_AL_LSB      = 24;
  // Mode register bit positions
  localparam int MR1_DLL_DIS_BIT  = 0;
  localparam int MR0_DLL_RST_BIT  = 8;
  localparam int MR0_CL_LSB       = 4;
  localparam int MR1_AL_LSB       = 3;
  localparam int MR2_CWL_LSB      = 3;
  // Mode register reset values
  localparam logic [15:0] MR0_RESET = 16'h0020;
  localparam logic [15:0] MR1_RESET = 16'h0000;
  localparam logic [15:0] MR2_RESET = 16'h0008;
  // Latency figures
  localparam logic [4:0] CL_BASE       = 5'h04;
  localparam logic [4:0] CWL_BASE      = 5'h05;
  localparam logic [4:0] DLL_OFF_CL    = 5'h06;
  localparam logic [4:0] DLL_OFF_CWL   = 5'h06;
  // DLL lock time in clock cycles
  localparam int         T_DLLK_NCK    = 512;
  // Decoded command
  typedef enum logic [2:0] {CMD_DESEL, CMD_NOP, CMD_MRS, CMD_READ, CMD_REFRESH, CMD_OTHER} dlm_cmd_type;
  // Low-power state
  typedef enum logic [1:0] {ST_ACTIVE, ST_SREF, ST_PDN} dlm_state_type;
  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : dlm_pkg

/* rtl/dlm_cmd_decode.sv */
// Command pin decoder
`timescale 1ns/1ps
module dlm_cmd_decode
(
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  output dlm_pkg::dlm_cmd_type cmd
);
  import dlm_pkg::*;
  // Chip select high masks every other pin
  always_comb
  begin
    if (cs_n)
      cmd = CMD_DESEL;
    else
    begin
      unique case ({ras_n, cas_n, we_n})
        3'h7:    cmd = CMD_NOP;
        3'h0:    cmd = CMD_MRS;
        3'h5:    cmd = CMD_READ;
        3'h1:    cmd = CMD_REFRESH;
        default: cmd = CMD_OTHER;
      endcase
    end
  end
endmodule : dlm_cmd_decode

/* rtl/dlm_dll_mode.sv */
// DLL mode, latency and low-power tracking of the memory device, with AHB-Lite registers
//
// Rules of the document
// R1 - NOP registers nothing new; running operations continue.
// R2 - Chip select high: other pins ignored, nothing new starts.
// R3 - MR1 A0 one enters DLL-off mode until written back to zero.
// R4 - DLL-control bit change accepted at any time.
// R5 - Controller keeps clock period within DLL-off frequency limit.
// R6 - DLL-off mode supports only read latency 6 with write latency 6.
// R7 - DLL-off read strobe launches AL+CL-1 cycles after read.
// R8 - Controller enters DLL-off from idle, writes MR1, waits, enters self refresh.
// R9 - Controller changes frequency in self refresh, gives stable clock before exit.
// R10 - After exit controller holds CKE high, ODT low, until mode delays end.
// R11 - Controller reprograms mode registers after exit delay.
// R12 - DLL-on: CKE high, ODT low until lock time after DLL reset.
// R13 - DLL-on order: MR1 A0 zero, MR0 A8 reset, then other registers.
// R14 - No lock-dependent command before lock time and calibration time.
// R15 - Frequency changes only in self refresh or precharge power-down.
// R16 - Self refresh ignores clock; new clock stable before exit.
// R17 - Frequency below minimum uses the DLL on-to-off sequence.
// R18 - Power-down change: wait entry delay, CKE and ODT held low.
// R19 - After power-down change: stable clock, exit, DLL reset, CKE high.
// R20 - During re-lock ODT low, CKE high, then normal operation.
// R21 - Self-refresh exit: only NOP or deselect during exit delay.
// R22 - DLL-enabled flag from mode writes selects launch cycle and latency set.
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module dlm_dll_mode
#(
  parameter int PEND_W = 32
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Memory command pins
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [15:0] addr,
  // Device-side results
  output logic             dqs_launch,
  output logic             dll_enabled,
  output logic             dll_locked
);
  import dlm_pkg::*;
  // Longest launch delay is AL (CL-1) plus CL = 21 cycles
  if (PEND_W < 24)
  begin : g_bad_width
    $error("PEND_W too small for longest read latency");
  end
  //////////////////////////////////////////////////////////////////////////////
  // Latency decode helpers
  function automatic logic [4:0] cl_of(input logic [15:0] mr0);
    cl_of = CL_BASE + {2'h0, mr0[MR0_CL_LSB +: 3]};
  endfunction : cl_of
  function automatic logic [4:0] al_of(input logic [15:0] mr1, input logic [4:0] cl);
    unique case (mr1[MR1_AL_LSB +: 2])
      2'h1:    al_of = cl - 5'h01;
      2'h2:    al_of = cl - 5'h02;
      default: al_of = 5'h00;
    endcase
  endfunction : al_of
  //////////////////////////////////////////////////////////////////////////////
  // Command decode
  dlm_cmd_type cmd;
  dlm_cmd_decode u_dec
  (
    .cs_n  (cs_n),
    .ras_n (ras_n),
    .cas_n (cas_n),
    .we_n  (we_n),
    .cmd   (cmd)
  );
  logic              cke_prev_r;
  dlm_state_type     state_r;
  logic [15:0]       mr0_r, mr1_r, mr2_r;
  logic              lat_err_r;
  logic [9:0]        lock_cnt_r;
  logic [PEND_W-1:0] pend_r;
  logic [1:0]        ctrl_r;
  logic [4:0]        cl, cwl, al, rd_delay;
  logic              cmd_live, mrs_live, rd_live, dll_rst;
  // Commands count only with CKE high now and before, outside self refresh
  assign cmd_live = cke && cke_prev_r && (state_r == ST_ACTIVE);
  assign mrs_live = cmd_live && (cmd == CMD_MRS);                       // R1 R2
  assign rd_live  = cmd_live && (cmd == CMD_READ);                      // R1 R2
  assign dll_rst  = mrs_live && (ba == 3'h0) && addr[MR0_DLL_RST_BIT];
  assign cl       = cl_of(mr0_r);
  assign cwl      = CWL_BASE + {2'h0, mr2_r[MR2_CWL_LSB +: 3]};
  assign al       = al_of(mr1_r, cl);
  assign dll_enabled = ~mr1_r[MR1_DLL_DIS_BIT];                         // R22
  // DLL off references the strobe one cycle earlier
  assign rd_delay = dll_enabled ? (al + cl) : (al + cl - 5'h01);        // R7 R22

  //////////////////////////////////////////////////////////////////////////////
  // CKE history and low-power state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cke_prev_r <= 1'b0;
      state_r    <= ST_ACTIVE;
    end
    else
    begin
      cke_prev_r <= cke;
      unique case (state_r)
        ST_ACTIVE:
          if (cke_prev_r && !cke && !cs_n)
            state_r <= (cmd == CMD_REFRESH) ? ST_SREF : ST_PDN;
          else if (cke_prev_r && !cke)
            state_r <= ST_PDN;
        // Clock and pins are don't care until CKE returns
        ST_SREF, ST_PDN:
          if (cke)
            state_r <= ST_ACTIVE;                                       // R16
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode registers: DLL control accepted at any MRS with CKE high now and before, outside self refresh, init or later
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mr0_r <= MR0_RESET;
      mr1_r <= MR1_RESET;
      mr2_r <= MR2_RESET;
    end
    else if (mrs_live)                                                  // R3 R4
    begin
      unique case (ba)
        3'h0:    mr0_r <= addr;
        3'h1:    mr1_r <= addr;
        3'h2:    mr2_r <= addr;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // DLL lock timer, restarted by DLL reset, held at the full lock count while DLL is off
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lock_cnt_r <= 10'h000;
    else if (dll_rst || !dll_enabled)
      lock_cnt_r <= 10'(T_DLLK_NCK);
    else if (lock_cnt_r != 10'h000)
      lock_cnt_r <= lock_cnt_r - 10'h001;
  end
  assign dll_locked = dll_enabled && (lock_cnt_r == 10'h000);

  //////////////////////////////////////////////////////////////////////////////
  // Latency legality in DLL-off; set wins over software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lat_err_r <= 1'b0;
    else if (!dll_enabled && (cl != DLL_OFF_CL || cwl != DLL_OFF_CWL)) // R6 R22
      lat_err_r <= 1'b1;
    else if (ctrl_r[CTRL_ERR_CLR_BIT])
      lat_err_r <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read strobe launch pipeline; earlier reads keep their slots
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pend_r <= '0;
    else if (rd_live)
      pend_r <= (pend_r >> 1) | (PEND_W'(1) << (rd_delay - 5'h01));     // R7
    else
      pend_r <= pend_r >> 1;                                            // R1 R2
  end
  assign dqs_launch = pend_r[0] & ctrl_r[CTRL_LAUNCH_EN_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic       ap_valid;
  assign ap_valid  = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= ap_valid && hwrite;
      wr_addr_r <= haddr;
    end
  end

  // Error-clear bit is a one-cycle strobe
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_r <= CTRL_RESET;
    else if (wr_pend_r && wr_addr_r == REG_CTRL_ADDR)
      ctrl_r <= hwdata[1:0];
    else
      ctrl_r[CTRL_ERR_CLR_BIT] <= 1'b0;
  end

  // Read data captured in the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (ap_valid && !hwrite)
    begin
      unique case (haddr)
        REG_CTRL_ADDR:   hrdata <= {30'h0, ctrl_r};
        REG_STATUS_ADDR: hrdata <= {3'h0, al, 3'h0, cwl, 3'h0, cl, 3'h0, lat_err_r,
                                    state_r == ST_PDN, state_r == ST_SREF, dll_locked, dll_enabled};
        REG_MR0_ADDR:    hrdata <= {16'h0, mr0_r};
        REG_MR1_ADDR:    hrdata <= {16'h0, mr1_r};
        REG_MR2_ADDR:    hrdata <= {16'h0, mr2_r};
        default:         hrdata <= 32'h0000_0000;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_rd_off_cl6;
    rd_live && !dll_enabled && cl == 5'h06 && al == 5'h00;
  endsequence
  sequence s_rd_on_cl6;
    rd_live && dll_enabled && cl == 5'h06 && al == 5'h00;
  endsequence
  property p_nop_inert;
    @(posedge hclk) disable iff (!hresetn)
      (cmd == CMD_NOP) |=> $stable(mr0_r) && $stable(mr1_r) && $stable(mr2_r);
  endproperty
  a_nop_inert: assert property (p_nop_inert) else $error("NOP changed a mode register"); // R1
  property p_desel_no_read;
    @(posedge hclk) disable iff (!hresetn)
      cs_n |=> pend_r == ($past(pend_r) >> 1);
  endproperty
  a_desel_no_read: assert property (p_desel_no_read) else $error("deselect started a read"); // R2
  property p_dll_off;
    @(posedge hclk) disable iff (!hresetn)
      mrs_live && ba == 3'h1 && addr[0] |=> !dll_enabled;
  endproperty
  a_dll_off: assert property (p_dll_off) else $error("MR1 A0 one did not disable DLL"); // R3
  property p_dll_on;
    @(posedge hclk) disable iff (!hresetn)
      !dll_enabled && mrs_live && ba == 3'h1 && !addr[0] |=> dll_enabled ##1 !dll_locked; // Only a real switch
  endproperty
  a_dll_on: assert property (p_dll_on) else $error("MR1 A0 zero did not enable DLL"); // R4
  property p_lat_err;
    @(posedge hclk) disable iff (!hresetn)
      !dll_enabled && (cl != DLL_OFF_CL || cwl != DLL_OFF_CWL) |=> lat_err_r;
  endproperty
  a_lat_err: assert property (p_lat_err) else $error("bad DLL-off latency not flagged"); // R6
  property p_launch_off;
    @(posedge hclk) disable iff (!hresetn)
      s_rd_off_cl6 |-> ##5 pend_r[0];
  endproperty
  a_launch_off: assert property (p_launch_off) else $error("DLL-off launch not at CL-1"); // R7
  property p_launch_on;
    @(posedge hclk) disable iff (!hresetn)
      s_rd_on_cl6 |-> ##6 pend_r[0];
  endproperty
  a_launch_on: assert property (p_launch_on) else $error("DLL-on launch not at CL"); // R22
  property p_sref_hold;
    @(posedge hclk) disable iff (!hresetn)
      state_r == ST_SREF && !cke |=> $stable(mr1_r) && state_r == ST_SREF;
  endproperty
  a_sref_hold: assert property (p_sref_hold) else $error("self refresh left without CKE"); // R16
  property p_relock;
    @(posedge hclk) disable iff (!hresetn)
      dll_rst |=> !dll_locked [*8];
  endproperty
  a_relock: assert property (p_relock) else $error("DLL locked too soon after reset"); // R12
endmodule : dlm_dll_mode

/* bench/dlm_ctrl_model.sv */
// Controller-side model that drives the memory clock-enable and command pins
`timescale 1ns/1ps
module dlm_ctrl_model
#(
  parameter int T_MOD_NCK = 12
)
(
  input  wire logic        clk,
  output logic             cke,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [2:0]       ba,
  output logic [15:0]      addr
);
  logic [2:0]  cmd_r  = 3'h7;
  logic [2:0]  ba_r   = 3'h0;
  logic [15:0] addr_r = 16'h0000;
  logic [7:0]  noise_r = 8'h00;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock never changes rate here, so every period limit holds trivially
  initial cke = 1'b1;
  initial cs_n = 1'b1;
  // Deselected pins scramble every cycle so no stale value passes for a command
  always @(posedge clk) noise_r <= noise_r + 8'h25;
  assign {ras_n, cas_n, we_n} = cs_n ? noise_r[2:0] : cmd_r;
  assign ba   = cs_n ? noise_r[5:3] : ba_r;
  assign addr = cs_n ? {noise_r, ~noise_r} : addr_r;
  ////////////////////////////////////////////////////////////////////////////////
  // One selected command cycle, then back to deselect
  task automatic send(input logic [2:0] c, input logic [2:0] b, input logic [15:0] a);
    @(posedge clk);
    cs_n   <= 1'b0;
    cmd_r  <= c;
    ba_r   <= b;
    addr_r <= a;
    @(posedge clk);
    cs_n   <= 1'b1;
  endtask : send
  // Mode write followed by the mode-register delay before anything else
  task automatic mrs(input logic [2:0] b, input logic [15:0] a);
    send(3'b000, b, a);
    repeat (T_MOD_NCK) @(posedge clk);
  endtask : mrs
  // Low-power entry from idle: refresh with clock enable falling, else power-down
  task automatic lp_enter(input logic sr);
    @(posedge clk);
    cke <= 1'b0;
    if (sr)
    begin
      cs_n  <= 1'b0;
      cmd_r <= 3'b001;
    end
    @(posedge clk);
    cs_n <= 1'b1;
  endtask : lp_enter
  // Exit holds clock enable high with deselect only through the exit delay
  task automatic lp_exit(input int n);
    @(posedge clk);
    cke <= 1'b1;
    repeat (n) @(posedge clk);
  endtask : lp_exit
endmodule : dlm_ctrl_model

/* bench/tb_dram_dll_mode_clock_change.sv */
// Self-checking testbench for the DLL-mode and latency tracking block
`timescale 1ns/1ps
module tb_dram_dll_mode_clock_change;
  import dlm_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  wire logic   hready;
  logic        hreadyout, hresp, cke, cs_n, ras_n, cas_n, we_n;
  logic [2:0]  ba;
  logic [15:0] addr;
  logic        dqs_launch, dll_enabled, dll_locked;
  int          n_fail = 0;
  int          tests_run = 0;
  localparam logic [31:0] M_DLL = 32'h1 << STAT_DLL_EN_BIT;
  localparam logic [31:0] M_LAT = 32'h1 << STAT_LAT_ERR_BIT;
  localparam logic [31:0] M_SR  = 32'h1 << STAT_SREF_BIT;
  localparam logic [31:0] M_PD  = 32'h1 << STAT_PDN_BIT;
  // Latency fields of the status word, and their value at reset
  localparam logic [31:0] M_LATF = (32'h1F << STAT_CL_LSB) | (32'h1F << STAT_CWL_LSB) | (32'h1F << STAT_AL_LSB);
  localparam logic [31:0] E_LAT6 = ({27'h0, DLL_OFF_CL} << STAT_CL_LSB) | ({27'h0, DLL_OFF_CWL} << STAT_CWL_LSB);
  ////////////////////////////////////////////////////////////////////////////////
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;
  dlm_dll_mode #(.PEND_W(32)) i_dlm_dll_mode (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr), .dqs_launch(dqs_launch), .dll_enabled(dll_enabled), .dll_locked(dll_locked));
  dlm_ctrl_model i_dlm_ctrl_model (.clk(hclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  // One AHB single transfer; waits on ready in both phases
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0000_0000, "response not OKAY");
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    ahb(a, 1'b0, 32'h0000_0000, q);
    chk(q & m, e, "register read");
  endtask : rd
  // Read command plus a trailing NOP; d is the launch cycle, negative for none
  task automatic t_read(input int d);
    logic [31:0] hits;
    hits = 32'h0000_0000;
    fork
      begin
        i_dlm_ctrl_model.send(3'b101, 3'h0, 16'h0000);
        i_dlm_ctrl_model.send(3'b111, 3'h1, 16'h0001);
      end
      begin
        @(posedge hclk);
        for (int k = 0; k < 16; k++)
        begin
          @(posedge hclk);
          hits[k] = dqs_launch;
        end
      end
    join
    chk(hits, (d < 0) ? 32'h0000_0000 : (32'h0000_0001 << d), "launch cycle");
  endtask : t_read
  // DLL reset restarts the lock count
  task automatic t_lock;
    int n;
    n = 0;
    i_dlm_ctrl_model.send(3'b000, 3'h0, 16'h0120);
    repeat (2) @(posedge hclk);
    chk({31'h0, dll_locked}, 32'h0000_0000, "lock kept after reset");
    while (dll_locked !== 1'b1 && n < 600)
    begin
      @(posedge hclk);
      n++;
    end
    chk({31'h0, (n >= 490 && n <= 520)}, 32'h0000_0001, "lock time");
  endtask : t_lock
  task automatic final_report;
    if (n_fail == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog far beyond the under two thousand cycles the sequence needs
  initial
  begin
    #100000;
    n_fail++;
    final_report;
  end
  initial
  begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, read-only mirrors and an unmapped word
    rd(REG_CTRL_ADDR, 32'hFFFF_FFFF, {30'h0, CTRL_RESET});
    rd(REG_MR0_ADDR, 32'h0000_FFFF, {16'h0, MR0_RESET});
    rd(REG_MR1_ADDR, 32'h0000_FFFF, {16'h0, MR1_RESET});
    rd(REG_MR2_ADDR, 32'h0000_FFFF, {16'h0, MR2_RESET});
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(REG_MR0_ADDR, 32'h0000_0000);
    rd(REG_MR0_ADDR, 32'h0000_FFFF, {16'h0, MR0_RESET});
    rd(REG_STATUS_ADDR, M_DLL, M_DLL);
    rd(REG_STATUS_ADDR, M_LATF, E_LAT6);
    // Launch timing with the DLL on, additive latency, and launch disabled
    t_read(6);
    i_dlm_ctrl_model.mrs(3'h1, 16'h0008);
    rd(REG_STATUS_ADDR, M_LATF, E_LAT6 | (32'h5 << STAT_AL_LSB));
    t_read(11);
    i_dlm_ctrl_model.mrs(3'h1, 16'h0000);
    wr(REG_CTRL_ADDR, 32'h0000_0000);
    t_read(-1);
    wr(REG_CTRL_ADDR, 32'h0000_0001);
    // DLL off, then scrambled deselect traffic must not disturb it
    i_dlm_ctrl_model.mrs(3'h1, 16'h0001);
    chk({31'h0, dll_enabled}, 32'h0000_0000, "dll off");
    rd(REG_STATUS_ADDR, M_DLL | M_LAT, 32'h0000_0000);
    t_read(5);
    repeat (300) @(posedge hclk);
    chk({31'h0, dll_enabled}, 32'h0000_0000, "dll off held");
    // Unsupported latencies flag an error until cleared
    i_dlm_ctrl_model.mrs(3'h0, 16'h0010);
    i_dlm_ctrl_model.mrs(3'h0, 16'h0020);
    rd(REG_STATUS_ADDR, M_LAT, M_LAT);
    wr(REG_CTRL_ADDR, 32'h0000_0003);
    rd(REG_STATUS_ADDR, M_LAT, 32'h0000_0000);
    i_dlm_ctrl_model.mrs(3'h2, 16'h0010);
    rd(REG_STATUS_ADDR, M_LAT, M_LAT);
    i_dlm_ctrl_model.mrs(3'h2, 16'h0008);
    wr(REG_CTRL_ADDR, 32'h0000_0003);
    rd(REG_CTRL_ADDR, 32'h0000_0003, 32'h0000_0001);
    // Self refresh ignores commands until exit
    i_dlm_ctrl_model.lp_enter(1'b1);
    rd(REG_STATUS_ADDR, M_SR | M_PD, M_SR);
    i_dlm_ctrl_model.send(3'b000, 3'h1, 16'h0000);
    chk({31'h0, dll_enabled}, 32'h0000_0000, "mode write in self refresh");
    i_dlm_ctrl_model.lp_exit(16);
    rd(REG_STATUS_ADDR, M_SR | M_PD | M_LAT, 32'h0000_0000);
    // DLL back on, reset, lock, then a locked read
    i_dlm_ctrl_model.mrs(3'h1, 16'h0000);
    chk({31'h0, dll_enabled}, 32'h0000_0001, "dll on");
    t_lock;
    t_read(6);
    // Precharge power-down and DLL reset after exit
    i_dlm_ctrl_model.lp_enter(1'b0);
    rd(REG_STATUS_ADDR, M_SR | M_PD, M_PD);
    i_dlm_ctrl_model.lp_exit(8);
    rd(REG_STATUS_ADDR, M_SR | M_PD, 32'h0000_0000);
    t_lock;
    final_report;
  end
endmodule : tb_dram_dll_mode_clock_change
